// >>> rtl/irq_entry_wake_context_save.sv
// Design decisions made here: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`default_nettype none

module irq_entry_wake_context_save (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Avalon-MM slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // External interrupt pin
  input wire logic ext_int_pin,
  // Core sequencer
  input wire logic core_sleeping,
  input wire logic sync_irq_req,
  input wire logic return_from_irq,
  input wire logic [14:0] return_pc,
  input wire logic [7:0] live_w,
  input wire logic [7:0] live_status,
  input wire logic [4:0] live_bank_select,
  input wire logic [15:0] live_pointer0,
  input wire logic [15:0] live_pointer1,
  input wire logic [6:0] live_pc_high_latch,
  output logic wake,
  output logic vector_fetch,
  output logic [13:0] vector_addr,
  output logic stack_push,
  output logic [14:0] stack_push_data,
  output logic restore_valid,
  output logic [7:0] restore_w,
  output logic [7:0] restore_status,
  output logic [4:0] restore_bank_select,
  output logic [15:0] restore_pointer0,
  output logic [15:0] restore_pointer1,
  output logic [6:0] restore_pc_high_latch,
  output logic [1:0] phase,
  // Interrupt
  output logic irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [1:0] q_reg;
  logic tcy_tick;
  logic ack_reg;
  logic bus_wr;
  logic [2:0] ctrl_reg;
  logic global_irq_enable;
  logic ext_pin_irq_enable;
  logic ext_edge_select;
  logic [3:0] evt_reg;
  logic [3:0] evt_next;
  logic [3:0] mask_reg;
  logic ext_pin_irq_flag;
  logic pin_prev_reg;
  logic edge_seen;
  logic edge_pend_reg;
  logic flag_window;
  logic flag_set;
  logic entry_req;
  logic entry_start;
  logic [1:0] lat_cnt_reg;
  logic vector_now;
  irq_entry_pkg::entry_state_t state_reg;
  logic [7:0] shadow_w_reg;
  logic [7:0] shadow_status_reg;
  logic [4:0] shadow_bank_select_reg;
  logic [15:0] shadow_pointer0_reg;
  logic [15:0] shadow_pointer1_reg;
  logic [6:0] shadow_pc_high_latch_reg;

  assign global_irq_enable = ctrl_reg[irq_entry_pkg::CTRL_GLOBAL_EN_BIT];
  assign ext_pin_irq_enable = ctrl_reg[irq_entry_pkg::CTRL_EXT_EN_BIT];
  assign ext_edge_select = ctrl_reg[irq_entry_pkg::CTRL_EDGE_BIT];
  assign ext_pin_irq_flag = evt_reg[irq_entry_pkg::EVT_EXT_BIT];

  // ----------------------------------------------------------------
  // Instruction cycle phases
  // ----------------------------------------------------------------

  // Four phases per instruction cycle, tick at end of Q4
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      q_reg <= irq_entry_pkg::PHASE_Q1;
    end else begin
      q_reg <= q_reg + 2'h1;
    end
  end

  assign tcy_tick = (q_reg == irq_entry_pkg::PHASE_Q4);
  assign phase = q_reg;

  // ----------------------------------------------------------------
  // Avalon-MM slave
  // ----------------------------------------------------------------

  // One wait state on every access
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (read | write) & ~ack_reg;
    end
  end

  assign waitrequest = (read | write) & ~ack_reg;
  assign bus_wr = write & ack_reg;

  // Read data captured in the wait cycle, unmapped reads zero
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      readdata <= 32'h0000_0000;
    end else if (read && !ack_reg) begin
      case (address)
        irq_entry_pkg::CTRL_OFS: readdata <= {29'h0000_0000, ctrl_reg};
        irq_entry_pkg::EVT_STATUS_OFS: readdata <= {28'h000_0000, evt_reg};
        irq_entry_pkg::EVT_MASK_OFS: readdata <= {28'h000_0000, mask_reg};
        irq_entry_pkg::SHADOW_W_OFS: readdata <= {24'h00_0000, shadow_w_reg};
        irq_entry_pkg::SHADOW_STATUS_OFS: readdata <= {24'h00_0000, shadow_status_reg};
        irq_entry_pkg::SHADOW_BANK_SELECT_OFS: readdata <= {27'h000_0000, shadow_bank_select_reg};
        irq_entry_pkg::SHADOW_POINTER0_OFS: readdata <= {16'h0000, shadow_pointer0_reg};
        irq_entry_pkg::SHADOW_POINTER1_OFS: readdata <= {16'h0000, shadow_pointer1_reg};
        irq_entry_pkg::SHADOW_PC_HIGH_LATCH_OFS: readdata <= {25'h000_0000, shadow_pc_high_latch_reg};
        default: readdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------

  // Software write, hardware clears on entry and sets on return
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ctrl_reg <= irq_entry_pkg::CTRL_RESET;
    end else begin
      if (bus_wr && address == irq_entry_pkg::CTRL_OFS) begin
        ctrl_reg <= writedata[2:0];
      end
      if (vector_now) begin
        ctrl_reg[irq_entry_pkg::CTRL_GLOBAL_EN_BIT] <= 1'b0;
      end else if (return_from_irq) begin
        ctrl_reg[irq_entry_pkg::CTRL_GLOBAL_EN_BIT] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // External pin edge detection
  // ----------------------------------------------------------------

  // Previous pin level
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pin_prev_reg <= 1'b0;
    end else begin
      pin_prev_reg <= ext_int_pin;
    end
  end

  assign edge_seen = ext_edge_select ? (ext_int_pin & ~pin_prev_reg) : (~ext_int_pin & pin_prev_reg);
  // flag may set only in Q4 or Q1
  assign flag_window = (q_reg == irq_entry_pkg::PHASE_Q4) || (q_reg == irq_entry_pkg::PHASE_Q1);
  assign flag_set = (edge_seen | edge_pend_reg) & flag_window;

  // Edge held until the flag window opens
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      edge_pend_reg <= 1'b0;
    end else if (flag_window) begin
      edge_pend_reg <= 1'b0;
    end else if (edge_seen) begin
      edge_pend_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Event status, mask and interrupt output
  // ----------------------------------------------------------------

  // Write one clears, a new event wins over the clear
  always_comb begin
    evt_next = evt_reg;
    if (bus_wr && address == irq_entry_pkg::EVT_STATUS_OFS) begin
      evt_next = evt_reg & ~writedata[3:0];
    end
    if (flag_set) begin
      evt_next[irq_entry_pkg::EVT_EXT_BIT] = 1'b1;
    end
    if (wake) begin
      evt_next[irq_entry_pkg::EVT_WAKE_BIT] = 1'b1;
    end
    if (vector_now) begin
      evt_next[irq_entry_pkg::EVT_ENTRY_BIT] = 1'b1;
    end
    if (return_from_irq) begin
      evt_next[irq_entry_pkg::EVT_RETURN_BIT] = 1'b1;
    end
  end

  // Sticky event bits
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      evt_reg <= irq_entry_pkg::EVT_RESET;
    end else begin
      evt_reg <= evt_next;
    end
  end

  // Mask register
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      mask_reg <= irq_entry_pkg::EVT_RESET;
    end else if (bus_wr && address == irq_entry_pkg::EVT_MASK_OFS) begin
      mask_reg <= writedata[3:0];
    end
  end

  assign irq = |(evt_reg & mask_reg);

  // ----------------------------------------------------------------
  // Wake from sleep
  // ----------------------------------------------------------------

  // only the pin source runs without the clock
  // wake needs the pin enable set beforehand
  assign wake = core_sleeping & ext_pin_irq_flag & ext_pin_irq_enable;

  // ----------------------------------------------------------------
  // Entry sequencer
  // ----------------------------------------------------------------

  // pin source active only while enabled
  // enabled pin flag or synchronous request
  // no entry starts while global enable is clear
  assign entry_req = global_irq_enable & ((ext_pin_irq_flag & ext_pin_irq_enable) | sync_irq_req);
  assign entry_start = (state_reg == irq_entry_pkg::ST_IDLE) && entry_req;
  // fixed count of instruction cycles to the fetch
  // counted on cycle ticks, not instructions
  // at least two ticks follow a wake
  assign vector_now = (state_reg == irq_entry_pkg::ST_COUNT) && tcy_tick && (lat_cnt_reg == 2'h1);

  // State register
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_reg <= irq_entry_pkg::ST_IDLE;
    end else begin
      case (state_reg)
        irq_entry_pkg::ST_IDLE: begin
          if (entry_req) begin
            state_reg <= irq_entry_pkg::ST_COUNT;
          end
        end
        irq_entry_pkg::ST_COUNT: begin
          if (vector_now) begin
            state_reg <= irq_entry_pkg::ST_SERVICE;
          end
        end
        irq_entry_pkg::ST_SERVICE: begin
          if (return_from_irq) begin
            state_reg <= irq_entry_pkg::ST_IDLE;
          end
        end
        default: state_reg <= irq_entry_pkg::ST_IDLE;
      endcase
    end
  end

  // Latency counter in instruction cycles
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      lat_cnt_reg <= 2'h0;
    end else if (entry_start) begin
      lat_cnt_reg <= irq_entry_pkg::ENTRY_LATENCY_TCY;
    end else if (state_reg == irq_entry_pkg::ST_COUNT && tcy_tick && lat_cnt_reg != 2'h0) begin
      lat_cnt_reg <= lat_cnt_reg - 2'h1;
    end
  end

  // Vector fetch and stack push strobes
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      vector_fetch <= 1'b0;
      stack_push <= 1'b0;
      stack_push_data <= 15'h0000;
      vector_addr <= 14'h0000;
    end else begin
      vector_fetch <= vector_now;
      stack_push <= vector_now;
      if (vector_now) begin
        stack_push_data <= return_pc;
        vector_addr <= irq_entry_pkg::IRQ_VECTOR;
      end
    end
  end

  // ----------------------------------------------------------------
  // Shadow registers
  // ----------------------------------------------------------------

  // capture on entry, timeout and power-down excluded
  // software writes land in the restored copy
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      shadow_w_reg <= 8'h00;
      shadow_status_reg <= 8'h00;
      shadow_bank_select_reg <= 5'h00;
      shadow_pointer0_reg <= 16'h0000;
      shadow_pointer1_reg <= 16'h0000;
      shadow_pc_high_latch_reg <= 7'h00;
    end else if (vector_now) begin
      shadow_w_reg <= live_w;
      shadow_status_reg <= live_status & irq_entry_pkg::STATUS_SAVE_MASK;
      shadow_bank_select_reg <= live_bank_select;
      shadow_pointer0_reg <= live_pointer0;
      shadow_pointer1_reg <= live_pointer1;
      shadow_pc_high_latch_reg <= live_pc_high_latch;
    end else if (bus_wr) begin
      case (address)
        irq_entry_pkg::SHADOW_W_OFS: shadow_w_reg <= writedata[7:0];
        irq_entry_pkg::SHADOW_STATUS_OFS: shadow_status_reg <= writedata[7:0] & irq_entry_pkg::STATUS_SAVE_MASK;
        irq_entry_pkg::SHADOW_BANK_SELECT_OFS: shadow_bank_select_reg <= writedata[4:0];
        irq_entry_pkg::SHADOW_POINTER0_OFS: shadow_pointer0_reg <= writedata[15:0];
        irq_entry_pkg::SHADOW_POINTER1_OFS: shadow_pointer1_reg <= writedata[15:0];
        irq_entry_pkg::SHADOW_PC_HIGH_LATCH_OFS: shadow_pc_high_latch_reg <= writedata[6:0];
        default: shadow_w_reg <= shadow_w_reg;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      restore_valid <= 1'b0;
      restore_w <= 8'h00;
      restore_status <= 8'h00;
      restore_bank_select <= 5'h00;
      restore_pointer0 <= 16'h0000;
      restore_pointer1 <= 16'h0000;
      restore_pc_high_latch <= 7'h00;
    end else begin
      restore_valid <= return_from_irq;
      if (return_from_irq) begin
        restore_w <= shadow_w_reg;
        restore_status <= shadow_status_reg;
        restore_bank_select <= shadow_bank_select_reg;
        restore_pointer0 <= shadow_pointer0_reg;
        restore_pointer1 <= shadow_pointer1_reg;
        restore_pc_high_latch <= shadow_pc_high_latch_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------

  sequence s_entry_taken;
    entry_start;
  endsequence

  sequence s_fetch_issued;
    ##[10:13] vector_fetch;
  endsequence

  a_flag_window: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(ext_pin_irq_flag) |-> ($past(q_reg) == irq_entry_pkg::PHASE_Q4 || $past(q_reg) == irq_entry_pkg::PHASE_Q1))
    else $error("pin flag set outside Q4-Q1");

  a_edge_sets_flag: assert property (@(posedge clock) disable iff (!reset_n)
    edge_seen |-> ##[1:3] ext_pin_irq_flag)
    else $error("valid edge did not set pin flag");

  a_entry_latency: assert property (@(posedge clock) disable iff (!reset_n)
    s_entry_taken |-> s_fetch_issued)
    else $error("vector fetch outside latency window");

  a_global_cleared: assert property (@(posedge clock) disable iff (!reset_n)
    vector_fetch |-> !global_irq_enable && $past(global_irq_enable, 2))
    else $error("global enable not cleared on entry");

  a_push_vector: assert property (@(posedge clock) disable iff (!reset_n)
    vector_fetch |-> stack_push && vector_addr == irq_entry_pkg::IRQ_VECTOR && stack_push_data == $past(return_pc))
    else $error("entry without stack push at vector");

  a_shadow_save: assert property (@(posedge clock) disable iff (!reset_n)
    vector_fetch |-> shadow_w_reg == $past(live_w) && shadow_bank_select_reg == $past(live_bank_select)
      && shadow_status_reg == ($past(live_status) & irq_entry_pkg::STATUS_SAVE_MASK))
    else $error("shadow copy mismatch on entry");

  a_return_restore: assert property (@(posedge clock) disable iff (!reset_n)
    return_from_irq |=> restore_valid && restore_w == $past(shadow_w_reg) && global_irq_enable)
    else $error("return did not restore context");

  a_wake_next_instr: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(wake) |-> !vector_fetch [*5])
    else $error("vectored before instruction after sleep");

  a_wake_source: assert property (@(posedge clock) disable iff (!reset_n)
    wake |-> core_sleeping && ext_pin_irq_enable && ext_pin_irq_flag)
    else $error("wake from unsupported source");

endmodule : irq_entry_wake_context_save

`default_nettype wire

// >>> rtl/irq_entry_pkg.sv
package irq_entry_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] EVT_STATUS_OFS = 8'h04;
  localparam logic [7:0] EVT_MASK_OFS = 8'h08;
  localparam logic [7:0] SHADOW_W_OFS = 8'h10;
  localparam logic [7:0] SHADOW_STATUS_OFS = 8'h14;
  localparam logic [7:0] SHADOW_BANK_SELECT_OFS = 8'h18;
  localparam logic [7:0] SHADOW_POINTER0_OFS = 8'h1C;
  localparam logic [7:0] SHADOW_POINTER1_OFS = 8'h20;
  localparam logic [7:0] SHADOW_PC_HIGH_LATCH_OFS = 8'h24;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_GLOBAL_EN_BIT = 0;
  localparam int CTRL_EXT_EN_BIT = 1;
  localparam int CTRL_EDGE_BIT = 2;
  localparam int EVT_EXT_BIT = 0;
  localparam int EVT_WAKE_BIT = 1;
  localparam int EVT_ENTRY_BIT = 2;
  localparam int EVT_RETURN_BIT = 3;
  localparam int EVT_WIDTH = 4;

  // Status bits kept out of the shadow copy (timeout and power-down)
  localparam logic [7:0] STATUS_SAVE_MASK = 8'hE7;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [3:0] EVT_RESET = 4'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLOCK_MHZ = 100;
  localparam int PHASES_PER_TCY = 4;
  localparam logic [1:0] PHASE_Q1 = 2'h0;
  localparam logic [1:0] PHASE_Q4 = 2'h3;
  localparam logic [1:0] ENTRY_LATENCY_TCY = 2'h3;
  localparam logic [13:0] IRQ_VECTOR = 14'h0004;

  // Entry sequence states
  typedef enum logic [1:0] {ST_IDLE, ST_COUNT, ST_SERVICE} entry_state_t;

endpackage : irq_entry_pkg

// >>> tb/core_model.sv
`timescale 1ns/1ps
`default_nettype none

module core_model (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Bench commands
  input wire logic sleep_cmd,
  input wire logic ret_cmd,
  input wire logic [31:0] seed,
  // From the entry block
  input wire logic wake,
  input wire logic vector_fetch,
  // To the entry block
  output logic core_sleeping,
  output logic return_from_irq,
  output logic [14:0] return_pc,
  output logic [7:0] live_w,
  output logic [7:0] live_status,
  output logic [4:0] live_bank_select,
  output logic [15:0] live_pointer0,
  output logic [15:0] live_pointer1,
  output logic [6:0] live_pc_high_latch
);
  logic in_service_reg;

  // Live working registers follow the seed
  always_ff @(posedge clock) begin
    return_pc <= seed[14:0];
    live_w <= seed[7:0];
    live_status <= seed[15:8];
    live_bank_select <= seed[20:16];
    live_pointer0 <= seed[31:16];
    live_pointer1 <= seed[15:0] ^ 16'hFFFF;
    live_pc_high_latch <= seed[30:24];
  end

  // Sleep held until a wake request
  // wake resumes core
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      core_sleeping <= 1'b0;
    end else if (wake) begin
      core_sleeping <= 1'b0;
    end else if (sleep_cmd) begin
      core_sleeping <= 1'b1;
    end
  end

  // Return pulse only from inside a service routine
  // single return
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      in_service_reg <= 1'b0;
      return_from_irq <= 1'b0;
    end else begin
      return_from_irq <= ret_cmd & in_service_reg;
      if (vector_fetch) begin
        in_service_reg <= 1'b1;
      end else if (return_from_irq) begin
        in_service_reg <= 1'b0;
      end
    end
  end
endmodule : core_model

`default_nettype wire

// >>> tb/irq_entry_wake_context_save_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHECK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
  $display("mismatch at %0t got %h exp %h", $time, (g), (e)); end end

module irq_entry_wake_context_save_bench;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic ext_int_pin = 1'b0;
  logic sync_irq_req = 1'b0;
  logic sleep_cmd = 1'b0;
  logic ret_cmd = 1'b0;
  logic [31:0] seed = 32'h3bcd_5890;
  logic [31:0] readdata, rdata;
  logic waitrequest, core_sleeping, return_from_irq, wake, vector_fetch, stack_push, restore_valid, irq;
  logic [14:0] return_pc, stack_push_data;
  logic [7:0] live_w, live_status, restore_w, restore_status;
  logic [4:0] live_bank_select, restore_bank_select;
  logic [15:0] live_pointer0, live_pointer1, restore_pointer0, restore_pointer1;
  logic [6:0] live_pc_high_latch, restore_pc_high_latch;
  logic [13:0] vector_addr;
  logic [1:0] phase;
  int err_count = 0;
  int n_compared = 0;
  int vf_count = 0;
  int lat, n;
  int sh_exp [6];
  logic [7:0] sh_ofs [6] = '{irq_entry_pkg::SHADOW_W_OFS, irq_entry_pkg::SHADOW_STATUS_OFS,
    irq_entry_pkg::SHADOW_BANK_SELECT_OFS, irq_entry_pkg::SHADOW_POINTER0_OFS,
    irq_entry_pkg::SHADOW_POINTER1_OFS, irq_entry_pkg::SHADOW_PC_HIGH_LATCH_OFS};
  logic [7:0] rst_ofs [4] = '{irq_entry_pkg::CTRL_OFS, irq_entry_pkg::EVT_STATUS_OFS,
    irq_entry_pkg::EVT_MASK_OFS, 8'h30};

  // Clock and vector fetch counter
  always #5 clock = ~clock;
  always @(posedge clock) if (vector_fetch === 1'b1) vf_count <= vf_count + 1;

  // ----------------------------------------------------------------
  // Instances
  // ----------------------------------------------------------------
  irq_entry_wake_context_save irq_entry_wake_context_save_i (.clock, .reset_n, .address, .read, .write,
    .writedata, .readdata, .waitrequest, .ext_int_pin, .core_sleeping, .sync_irq_req, .return_from_irq,
    .return_pc, .live_w, .live_status, .live_bank_select, .live_pointer0, .live_pointer1,
    .live_pc_high_latch, .wake, .vector_fetch, .vector_addr, .stack_push, .stack_push_data,
    .restore_valid, .restore_w, .restore_status, .restore_bank_select, .restore_pointer0,
    .restore_pointer1, .restore_pc_high_latch, .phase, .irq);
  core_model core_model_i (.clock, .reset_n, .sleep_cmd, .ret_cmd, .seed, .wake, .vector_fetch,
    .core_sleeping, .return_from_irq, .return_pc, .live_w, .live_status, .live_bank_select,
    .live_pointer0, .live_pointer1, .live_pc_high_latch);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report

  // Avalon access, held until waitrequest is seen low
  task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clock);
    address <= a;
    read <= rd;
    write <= ~rd;
    writedata <= d;
    for (k = 0; k < 16; k++) begin
      @(posedge clock);
      if (waitrequest === 1'b0) break;
    end
    if (k == 16) begin
      err_count++;
      final_report();
    end
    rdata = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b0, a, d);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b1, a, 32'h0000_0000);
    `CHECK(rdata, e)
  endtask : rd_chk

  task automatic pin_edge(input logic lvl);
    @(posedge clock);
    ext_int_pin <= lvl;
    repeat (8) @(posedge clock);
  endtask : pin_edge

  task automatic settle;
    @(negedge clock);
  endtask : settle

  // One full entry, service and return with shadow checks
  task automatic do_entry(input logic trig, input int hi, input logic [31:0] ctrl);
    int i;
    @(posedge clock);
    seed <= lfsr_next(seed);
    repeat (2) @(posedge clock);
    sh_exp = '{seed[7:0], seed[15:8] & irq_entry_pkg::STATUS_SAVE_MASK, seed[20:16], seed[31:16],
      seed[15:0] ^ 16'hFFFF, seed[30:24]};
    if (trig) sync_irq_req <= 1'b1;
    else ext_int_pin <= 1'b1;
    for (lat = 1; lat <= hi; lat++) begin
      @(negedge clock);
      if (vector_fetch === 1'b1) break;
    end
    `CHECK(lat >= 9 && lat <= hi, 1'b1)
    if (lat > hi) final_report();
    `CHECK(phase, irq_entry_pkg::PHASE_Q1)
    `CHECK(stack_push, 1'b1)
    `CHECK(stack_push_data, seed[14:0])
    `CHECK(vector_addr, irq_entry_pkg::IRQ_VECTOR)
    @(posedge clock);
    sync_irq_req <= 1'b0;
    rd_chk(irq_entry_pkg::CTRL_OFS, ctrl & 32'h0000_0006);
    rd_chk(irq_entry_pkg::EVT_STATUS_OFS, trig ? 32'h0000_0004 : 32'h0000_0005);
    wr(irq_entry_pkg::EVT_STATUS_OFS, 32'h0000_000F);
    for (i = 0; i < 6; i++) rd_chk(sh_ofs[i], sh_exp[i]);
    wr(irq_entry_pkg::SHADOW_W_OFS, 32'h0000_005A);
    sh_exp[0] = 8'h5A;
    seed <= lfsr_next(seed);
    @(posedge clock);
    ret_cmd <= 1'b1;
    @(posedge clock);
    ret_cmd <= 1'b0;
    ext_int_pin <= 1'b0;
    for (i = 0; i < 8; i++) begin
      @(negedge clock);
      if (restore_valid === 1'b1) break;
    end
    `CHECK(i < 8, 1'b1)
    if (i == 8) final_report();
    `CHECK(restore_w, sh_exp[0])
    `CHECK(restore_status, sh_exp[1])
    `CHECK(restore_bank_select, sh_exp[2])
    `CHECK(restore_pointer0, sh_exp[3])
    `CHECK(restore_pointer1, sh_exp[4])
    `CHECK(restore_pc_high_latch, sh_exp[5])
    rd_chk(irq_entry_pkg::CTRL_OFS, ctrl);
    wr(irq_entry_pkg::EVT_STATUS_OFS, 32'h0000_000F);
  endtask : do_entry

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    // Reset state and unmapped space
    wr(8'h30, 32'hFFFF_FFFF);
    foreach (rst_ofs[i]) rd_chk(rst_ofs[i], 32'h0000_0000);
    `CHECK(vector_addr, 14'h0000)
    // Edge polarity with pin and global enables off
    for (int e = 1; e >= 0; e--) begin
      wr(irq_entry_pkg::CTRL_OFS, e << irq_entry_pkg::CTRL_EDGE_BIT);
      pin_edge(1'b1);
      rd_chk(irq_entry_pkg::EVT_STATUS_OFS, e);
      wr(irq_entry_pkg::EVT_STATUS_OFS, 32'h0000_0001);
      pin_edge(1'b0);
      rd_chk(irq_entry_pkg::EVT_STATUS_OFS, 1 - e);
    end
    // Interrupt output masked, unmasked and cleared
    settle();
    `CHECK(irq, 1'b0)
    wr(irq_entry_pkg::EVT_MASK_OFS, 32'h0000_0001);
    settle();
    `CHECK(irq, 1'b1)
    wr(irq_entry_pkg::EVT_STATUS_OFS, 32'h0000_0001);
    settle();
    `CHECK(irq, 1'b0)
    wr(irq_entry_pkg::EVT_MASK_OFS, 32'h0000_0000);
    // Sleep with pin disabled, then enabled
    wr(irq_entry_pkg::CTRL_OFS, 32'h0000_0004);
    @(posedge clock);
    sleep_cmd <= 1'b1;
    @(posedge clock);
    sleep_cmd <= 1'b0;
    pin_edge(1'b1);
    `CHECK(core_sleeping, 1'b1)
    `CHECK(wake, 1'b0)
    pin_edge(1'b0);
    wr(irq_entry_pkg::EVT_STATUS_OFS, 32'h0000_000F);
    wr(irq_entry_pkg::CTRL_OFS, 32'h0000_0006);
    sync_irq_req <= 1'b1;
    repeat (10) @(posedge clock);
    `CHECK(core_sleeping, 1'b1)
    sync_irq_req <= 1'b0;
    n = vf_count;
    pin_edge(1'b1);
    `CHECK(core_sleeping, 1'b0)
    repeat (30) @(posedge clock);
    `CHECK(vf_count, n)
    wr(irq_entry_pkg::EVT_STATUS_OFS, 32'h0000_000F);
    pin_edge(1'b0);
    // Pin entry with all enables
    wr(irq_entry_pkg::CTRL_OFS, 32'h0000_0007);
    do_entry(1'b0, 20, 32'h0000_0007);
    // Synchronous request blocked, then taken
    wr(irq_entry_pkg::CTRL_OFS, 32'h0000_0000);
    n = vf_count;
    sync_irq_req <= 1'b1;
    repeat (30) @(posedge clock);
    `CHECK(vf_count, n)
    sync_irq_req <= 1'b0;
    wr(irq_entry_pkg::CTRL_OFS, 32'h0000_0001);
    do_entry(1'b1, 16, 32'h0000_0001);
    final_report();
  end
endmodule : irq_entry_wake_context_save_bench

`default_nettype wire
